/* bench/flash_array_model.sv */
// behavioural flash array with random accept and completion delays
`timescale 1ns/1ps
`default_nettype none
module flash_array_model
  import flash_word_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire flash_req_t flash_req,
  output logic flash_ready,
  output logic flash_done,
  output logic [15:0] flash_rdata
);
  logic [15:0] mem [logic [23:0]];
  logic [23:0] a;
  int cnt = -1;
  initial begin
    flash_ready = 1'b0;
    flash_done = 1'b0;
    flash_rdata = 16'h0000;
  end
  always @(posedge sys_clk) begin
    flash_done <= 1'b0;
    flash_rdata <= ~flash_rdata; // no stale data outside done
    flash_ready <= !reset && cnt < 0 && $urandom % 3 == 0;
    if (flash_req.valid && flash_ready && cnt < 0) begin
      a = flash_req.addr;
      if (flash_req.write) mem[a] = flash_req.wdata;
      cnt = $urandom % 6;
      flash_ready <= 1'b0;
    end else if (cnt == 0) begin
      flash_done <= 1'b1;
      flash_rdata <= mem.exists(a) ? mem[a] : 16'h5a5a;
      cnt = -1;
    end else if (cnt > 0) cnt = cnt - 1;
  end
endmodule
`default_nettype wire

/* bench/testbench.sv */
// self-checking bench for the flash word access sequencer
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import flash_word_pkg::*;
  logic sys_clk, reset, instr_valid, data_wr_en, flash_ready, flash_done;
  logic [15:0] instr_opcode, flash_rdata, dp, v;
  logic [23:0] a;
  flash_addr_t addr_regs;
  flash_data_t data_wr, data_regs;
  flash_req_t flash_req;
  logic [7:0] extended_config_reg;
  logic instr_accept, flash_op_pending, fetch_block;
  logic [15:0] exp_q[$];
  int mismatches = 0;
  int n_checks = 0;
  flash_word_access u_flash_word_access(.sys_clk(sys_clk), .reset(reset),
    .instr_valid(instr_valid), .instr_opcode(instr_opcode), .addr_regs(addr_regs),
    .data_wr(data_wr), .data_wr_en(data_wr_en), .flash_base(FLASH_BASE_RST),
    .flash_limit(FLASH_LIMIT_RST), .instr_accept(instr_accept), .data_regs(data_regs),
    .extended_config_reg(extended_config_reg), .flash_op_pending(flash_op_pending),
    .fetch_block(fetch_block), .flash_req(flash_req), .flash_ready(flash_ready),
    .flash_done(flash_done), .flash_rdata(flash_rdata));
  flash_array_model u_flash_array_model(.sys_clk(sys_clk), .reset(reset),
    .flash_req(flash_req), .flash_ready(flash_ready), .flash_done(flash_done),
    .flash_rdata(flash_rdata));
  always #2.5 sys_clk = ~sys_clk;
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic ld(input logic [15:0] d);
    data_wr <= d;
    data_wr_en <= 1'b1;
    @(posedge sys_clk);
    data_wr_en <= 1'b0;
    dp = d;
  endtask
  task automatic op(input logic wr, input logic [23:0] ad, input logic ok, input logic [15:0] e);
    int n;
    addr_regs <= ad;
    instr_opcode <= wr ? OPC_FLASH_WRITE : OPC_FLASH_READ;
    instr_valid <= 1'b1;
    #1 chk(instr_accept, 1'b1, "accept");
    if (ok) exp_q.push_back(e);
    @(posedge sys_clk);
    instr_valid <= 1'b0;
    addr_regs <= ~ad; // address must be latched at issue
    #1 chk(flash_op_pending, ok, "pending");
    chk(fetch_block, ok, "fetch_block");
    chk(flash_req.valid, ok, "req_valid");
    chk(extended_config_reg, {7'h00, ok}, "ext_cfg");
    n = 0;
    // look 1 ns past each edge so the flag has settled
    while (flash_op_pending !== 1'b0 && n < 300) begin
      @(posedge sys_clk);
      #1 n++;
    end
    if (flash_op_pending !== 1'b0) begin
      mismatches++;
      final_report();
    end
    @(posedge sys_clk);
    @(posedge sys_clk);
  endtask
  always @(posedge sys_clk) begin
    if (!reset && $fell(flash_op_pending)) begin
      if (exp_q.size() == 0) chk(16'h0, 16'h1, "unexpected op");
      else chk(data_regs, exp_q.pop_front(), "data_regs");
    end
  end
  initial begin
    sys_clk = 0;
    reset = 1;
    instr_valid = 0;
    instr_opcode = 16'h0000;
    addr_regs = 24'h000000;
    data_wr = 16'h0000;
    data_wr_en = 0;
    void'($urandom(32'h9c31));
    repeat (3) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    for (int i = 0; i < 8; i++) begin
      a = i == 0 ? FLASH_BASE_RST : i == 1 ? FLASH_LIMIT_RST - 24'h1 :
        {FLASH_BASE_RST[23:16], 16'($urandom) & 16'hfffe};
      v = 16'($urandom);
      ld(v);
      op(1'b1, a, 1'b1, v);
      ld(~v);
      op(1'b0, a, 1'b1, v);
      $display("test write/read %0d done", i);
    end
    // fresh known pair, so a refused read that loads anything shows up
    ld(16'($urandom));
    op(1'b0, FLASH_LIMIT_RST + 24'h1, 1'b0, 16'h0);
    op(1'b1, FLASH_BASE_RST - 24'h1, 1'b0, 16'h0);
    chk(data_regs, dp, "data after refused");
    $display("test out of range done");
    reset <= 1'b1;
    repeat (3) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    #1 chk(data_regs, DATA_RST, "data after reset");
    chk(extended_config_reg, EXT_CFG_RST, "ext_cfg after reset");
    chk(16'(exp_q.size()), 16'h0000, "notes left");
    $display("test reset done");
    final_report();
  end
endmodule
`default_nettype wire

/* hw/flash_range_check.sv */
// decides whether a byte address falls inside the program flash region
`timescale 1ns/1ps
`default_nettype none
module flash_range_check
  import flash_word_pkg::*;
(
  input wire logic [23:0] addr,
  input wire logic [23:0] base,
  input wire logic [23:0] limit,
  output logic in_flash
);
  assign in_flash = (addr >= base) && (addr <= limit);
endmodule
`default_nettype wire

/* hw/flash_word_access.sv */
// single-word program flash read/write sequencer with pending flag
`timescale 1ns/1ps
`default_nettype none
module flash_word_access
  import flash_word_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic instr_valid,
  input wire logic [15:0] instr_opcode,
  input wire flash_addr_t addr_regs,
  input wire flash_data_t data_wr,
  input wire logic data_wr_en,
  input wire logic [23:0] flash_base,
  input wire logic [23:0] flash_limit,
  output logic instr_accept,
  output flash_data_t data_regs,
  output logic [7:0] extended_config_reg,
  output logic flash_op_pending,
  output logic fetch_block,
  output flash_req_t flash_req,
  input wire logic flash_ready,
  input wire logic flash_done,
  input wire logic [15:0] flash_rdata
);
  typedef enum logic [1:0] {ST_IDLE, ST_REQ, ST_WAIT} seq_state_t;

  seq_state_t state_q, state_d;
  flash_req_t req_q, req_d;
  flash_data_t data_q, data_d;
  logic pend_q, pend_d;

  wire logic [23:0] full_addr;
  wire logic in_flash;
  wire logic is_read;
  wire logic is_write;
  wire logic issue;

  // byte address: x is bits 23:16, h is bits 15:8, l is bits 7:0
  assign full_addr = {addr_regs.addr_x, addr_regs.addr_h, addr_regs.addr_l};
  assign is_read = instr_valid && (instr_opcode == OPC_FLASH_READ);
  assign is_write = instr_valid && (instr_opcode == OPC_FLASH_WRITE);
  // out-of-region access never starts, flag stays clear
  assign issue = (is_read || is_write) && in_flash && (state_q == ST_IDLE);
  // the core never waits on us; accept in the issue cycle
  assign instr_accept = is_read || is_write;

  flash_range_check u_range (
    .addr(full_addr),
    .base(flash_base),
    .limit(flash_limit),
    .in_flash(in_flash)
  );

  always_comb begin
    state_d = state_q;
    req_d = req_q;
    data_d = data_q;
    pend_d = pend_q;
    if (data_wr_en) begin
      data_d = data_wr;
    end
    case (state_q)
      ST_IDLE: begin
        if (issue) begin
          req_d.valid = 1'b1;
          req_d.write = is_write;
          req_d.addr = full_addr;
          req_d.wdata = data_q;
          pend_d = 1'b1;
          state_d = ST_REQ;
        end
      end
      ST_REQ: begin
        if (flash_ready) begin
          req_d.valid = 1'b0;
          state_d = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (flash_done) begin
          if (!req_q.write) begin
            data_d = flash_rdata;
          end
          pend_d = 1'b0;
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
        req_d.valid = 1'b0;
        pend_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_q <= ST_IDLE;
      req_q <= '0;
      data_q <= DATA_RST;
      pend_q <= 1'b0;
    end else begin
      state_q <= state_d;
      req_q <= req_d;
      data_q <= data_d;
      pend_q <= pend_d;
    end
  end

  assign data_regs = data_q;
  assign flash_req = req_q;
  assign flash_op_pending = pend_q;
  // fetch from flash would collide with the running access
  assign fetch_block = pend_q;

  always_comb begin
    extended_config_reg = EXT_CFG_RST;
    extended_config_reg[PEND_BIT] = pend_q;
  end

  property p_issue_sets_pending;
    @(posedge sys_clk) disable iff (reset)
      issue |=> flash_op_pending && flash_req.valid;
  endproperty
  a_issue_sets_pending: assert property (p_issue_sets_pending)
    else $error("pending flag not set after issue");

  property p_out_of_range_noop;
    @(posedge sys_clk) disable iff (reset)
      (is_read || is_write) && !in_flash && !flash_op_pending |=> !flash_op_pending;
  endproperty
  a_out_of_range_noop: assert property (p_out_of_range_noop)
    else $error("out of range access started an operation");

  property p_done_clears;
    @(posedge sys_clk) disable iff (reset)
      (state_q == ST_WAIT) && flash_done |=> !flash_op_pending;
  endproperty
  a_done_clears: assert property (p_done_clears)
    else $error("pending flag not cleared on completion");

  property p_read_data;
    @(posedge sys_clk) disable iff (reset)
      (state_q == ST_WAIT) && flash_done && !req_q.write |=> data_regs == $past(flash_rdata);
  endproperty
  a_read_data: assert property (p_read_data)
    else $error("read data not loaded into data pair");

  property p_write_captures;
    @(posedge sys_clk) disable iff (reset)
      issue && is_write |=> flash_req.write && flash_req.wdata == $past(data_regs);
  endproperty
  a_write_captures: assert property (p_write_captures)
    else $error("write request missing captured data");

  property p_addr_stable;
    @(posedge sys_clk) disable iff (reset)
      flash_op_pending && $past(flash_op_pending) |-> $stable(flash_req.addr);
  endproperty
  a_addr_stable: assert property (p_addr_stable)
    else $error("address changed while pending");

  property p_addr_hi;
    @(posedge sys_clk) disable iff (reset)
      issue |=> flash_req.addr[15:8] == $past(addr_regs.addr_h);
  endproperty
  a_addr_hi: assert property (p_addr_hi)
    else $error("high byte not at bits 15:8");

  property p_accept_same_cycle;
    @(posedge sys_clk) disable iff (reset)
      instr_valid && (instr_opcode == OPC_FLASH_READ || instr_opcode == OPC_FLASH_WRITE)
        |-> instr_accept;
  endproperty
  a_accept_same_cycle: assert property (p_accept_same_cycle)
    else $error("instruction not accepted in one cycle");

  property p_fetch_block;
    @(posedge sys_clk) disable iff (reset)
      issue |=> fetch_block [*1] ##0 extended_config_reg[PEND_BIT];
  endproperty
  a_fetch_block: assert property (p_fetch_block)
    else $error("fetch not blocked while pending");

  property p_no_accept_idle;
    @(posedge sys_clk) disable iff (reset)
      !instr_valid |-> !instr_accept;
  endproperty
  a_no_accept_idle: assert property (p_no_accept_idle)
    else $error("accept raised with no instruction");

  property p_req_holds;
    @(posedge sys_clk) disable iff (reset)
      flash_req.valid && !flash_ready |=> flash_req.valid && $stable(flash_req);
  endproperty
  a_req_holds: assert property (p_req_holds)
    else $error("request changed before the array took it");

  property p_write_keeps_data;
    @(posedge sys_clk) disable iff (reset)
      (state_q == ST_WAIT) && flash_done && req_q.write && !data_wr_en |=> $stable(data_regs);
  endproperty
  a_write_keeps_data: assert property (p_write_keeps_data)
    else $error("write completion disturbed the data pair");

  property p_pending_tracks_state;
    @(posedge sys_clk) disable iff (reset)
      flash_op_pending == (state_q != ST_IDLE);
  endproperty
  a_pending_tracks_state: assert property (p_pending_tracks_state)
    else $error("pending flag out of step with sequencer");

  property p_refused_no_req;
    @(posedge sys_clk) disable iff (reset)
      (is_read || is_write) && !in_flash && !flash_op_pending |=> !flash_req.valid;
  endproperty
  a_refused_no_req: assert property (p_refused_no_req)
    else $error("out of range access raised a flash request");
endmodule
`default_nettype wire

/* hw/flash_word_pkg.sv */
// shared constants and carrier types for the flash word access sequencer
`default_nettype none
package flash_word_pkg;
  localparam logic [15:0] OPC_FLASH_READ = 16'h001b;
  localparam logic [15:0] OPC_FLASH_WRITE = 16'h001a;
  localparam int ADDR_W = 24;
  localparam int DATA_W = 16;
  localparam logic [23:0] FLASH_BASE_RST = 24'h010000;
  localparam logic [23:0] FLASH_LIMIT_RST = 24'h01ffff;
  localparam logic [15:0] DATA_RST = 16'h0000;
  localparam int PEND_BIT = 0;
  localparam logic [7:0] EXT_CFG_RST = 8'h00;

  typedef struct packed {
    logic [7:0] addr_x;
    logic [7:0] addr_h;
    logic [7:0] addr_l;
  } flash_addr_t;

  typedef struct packed {
    logic [7:0] data_h;
    logic [7:0] data_l;
  } flash_data_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [23:0] addr;
    logic [15:0] wdata;
  } flash_req_t;
endpackage
`default_nettype wire
